// >>> servo_limit_pkg.sv
// Shared constants and carriers of the current-limit reduction block.
// Assumes one 25 MHz clock and host access by parameter identifier.
// What this block does
// - Above continuous current, fill overcurrent time memory
// - Memory expired: limit to continuous, warn
// - Overcurrent time comes from identifier 0xf0
// - Below continuous current, drain the time memory
// - Memory recovery takes twice the overcurrent time
// - Digital input or CAN command cuts limit
// - Speed above threshold reduces limit linearly, flagged
// - Stage temperature warn, then reduce limit
// - Stage temperature stop level triggers emergency stop
// - Stage reduction off: warn zero or stop lower
// - Motor I2t overload warns, then reduces limit
// - Motor temperature warn, then reduce limit
// - Motor temperature stop level triggers emergency stop
// - Analog input 2 scales limit, flagged
// - Separate flags: stage reducing, stage at continuous
// - Memory prewarn above 80%, full at 100%
// - Flag whenever current exceeds continuous value
// - Summary flag for any limit reduction
// - Combine reductions, light reduced-current indicator
// - Temperatures readable at 0x49, 0x4a, 0x4b
// - Ramped, limited command readable at 0x22
// - Filtered display current readable at 0x5f
// - PWM pulses from quadrature and direct voltages
// - Lower of motor and servo settings applies
package servo_limit_pkg;
  // ****************************************
  // Parameter identifiers
  // ****************************************
  localparam logic [7:0] ID_SUM_CUR = 8'h20;
  localparam logic [7:0] ID_FIX_CMD = 8'h21;
  localparam logic [7:0] ID_RAMP_CMD = 8'h22;
  localparam logic [7:0] ID_DIRECT_AXIS_REFERENCE = 8'h23;
  localparam logic [7:0] ID_CMD = 8'h26;
  localparam logic [7:0] ID_IQ = 8'h27;
  localparam logic [7:0] ID_ID = 8'h28;
  localparam logic [7:0] ID_VQ = 8'h29;
  localparam logic [7:0] ID_VD = 8'h2A;
  localparam logic [7:0] ID_Q_ERR = 8'h38;
  localparam logic [7:0] ID_D_ERR = 8'h39;
  localparam logic [7:0] ID_SPD_THR = 8'h3C;
  localparam logic [7:0] ID_DIG_LIM = 8'h46;
  localparam logic [7:0] ID_ACT_LIM = 8'h48;
  localparam logic [7:0] ID_MOT_T = 8'h49;
  localparam logic [7:0] ID_STG_T = 8'h4A;
  localparam logic [7:0] ID_AIR_T = 8'h4B;
  localparam logic [7:0] ID_STG_STOP = 8'h4C;
  localparam logic [7:0] ID_STG_WARN = 8'h58;
  localparam logic [7:0] ID_DISP = 8'h5F;
  localparam logic [7:0] ID_VOUT = 8'h8A;
  localparam logic [7:0] ID_VRED = 8'h8B;
  localparam logic [7:0] ID_VTI = 8'h8D;
  localparam logic [7:0] ID_MOT_WARN = 8'hA2;
  localparam logic [7:0] ID_MOT_STOP = 8'hA3;
  localparam logic [7:0] ID_VKP = 8'hAC;
  localparam logic [7:0] ID_OC_TIME = 8'hF0;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [15:0] RST_OC_TIME = 16'h0005;
  localparam logic [15:0] RST_DIG_LIM = 16'h0064;
  localparam logic [15:0] RST_SPD_THR = 16'h7FFF;
  localparam logic [15:0] RST_STG_LVL = 16'h0000;
  localparam logic [15:0] RST_MOT_LVL = 16'h7FFF;
  localparam logic [15:0] RST_FIX_CMD = 16'h0000;
  localparam int MS_TIME_US = 1000;
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_CYCLES = (MS_TIME_US * 1000) / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int PREWARN_PCT = 80;
  localparam int LOAD_WARN_PCT = 80;
  localparam int FULL_PCT = 100;
  localparam int DISP_SHIFT = 4;
  // ****************************************
  // Carriers
  // ****************************************
  typedef enum logic [2:0] {
    OC_IDLE = 3'b001,
    OC_ACCUM = 3'b010,
    OC_LIMITED = 3'b100
  } oc_state_t;
  typedef struct packed {
    logic [15:0] current, iq, id, direct_axis_reference, speed;
    logic [15:0] motor_temp, stage_temp, air_temp;
    logic [15:0] analog2, i2t_load;
    logic [15:0] vq, vd, vout, vred, vkp, vti;
    logic signed [15:0] command;
  } meas_t;
  typedef struct packed {
    logic [15:0] motor_peak, motor_cont;
    logic [15:0] servo_peak, servo_cont;
    logic [15:0] rated_speed, i2t_limit, ramp_step;
    logic ana_enable, use_fixed;
  } limit_cfg_t;
  typedef struct packed {
    logic analog_limit_flag, dig_limit_flag, speed_limit_flag;
    logic motor_heat_limit_flag, stage_heat_limit_flag;
    logic stage_heat_to_continuous_flag;
    logic time_memory_full_flag, above_continuous_flag;
    logic time_memory_prewarn_flag, reduced_flag;
    logic stage_temp_warn, motor_temp_warn, load_warn, oc_warn;
  } flags_t;
endpackage

// >>> servo_current_limit_reduction.sv
// Current-limit reduction, supervision and parameter access.
// Assumes measured inputs synchronous to i_sys_clk and valid each cycle.
`timescale 1ns/10ps
module servo_current_limit_reduction #(
  parameter int MS_CYCLES = servo_limit_pkg::MS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire servo_limit_pkg::meas_t i_meas,
  input wire servo_limit_pkg::limit_cfg_t i_cfg,
  input wire logic i_dig_limit,
  input wire logic i_can_limit,
  input wire logic i_par_wr,
  input wire logic i_par_rd,
  input wire logic [7:0] i_par_id,
  input wire logic [15:0] i_par_wdata,
  output logic [15:0] o_par_rdata,
  output logic o_par_valid,
  output logic [15:0] o_limit,
  output logic signed [15:0] o_cmd_ramp,
  output servo_limit_pkg::flags_t o_flags,
  output logic o_reduced_led,
  output logic o_estop,
  output logic [1:0] o_pwm
);
  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    servo_limit_pkg::oc_state_t oc;
    logic [31:0] oc_mem;         // Overcurrent time memory, ms
    logic [15:0] ms_cnt;         // Millisecond prescaler
    logic drain_ph;              // Halves the drain rate
    logic [15:0] fix_cmd, spd_thr, dig_lim;
    logic [15:0] stg_stop, stg_warn;
    logic [15:0] mot_warn, mot_stop, oc_time;
    logic [15:0] limit;
    logic signed [15:0] cmd_ramp;
    logic [15:0] disp;           // Display filter state
    logic signed [15:0] q_err, d_err;
    servo_limit_pkg::flags_t flags;
    logic estop;
    logic [15:0] rdata;
    logic rvalid;
    logic [9:0] pwm_cnt;
    logic [1:0] pwm;
  } st_t;

  st_t st_ff;
  st_t nxt_st;

  // Linear fall from peak at lo to continuous at hi
  function automatic logic [15:0] lin_red(
    input logic [15:0] pk, input logic [15:0] cn,
    input logic [15:0] x, input logic [15:0] lo,
    input logic [15:0] hi);
    logic [31:0] span;
    logic [31:0] drop;
    span = 32'(hi) - 32'(lo);
    drop = 32'(pk) - 32'(cn);
    if (x <= lo) begin
      return pk;
    end
    if (x >= hi) begin
      return cn;
    end
    return pk - 16'((drop * (32'(x) - 32'(lo))) / span);
  endfunction

  function automatic logic [15:0] min2(
    input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  // ****************************************
  // Reduction sources
  // ****************************************
  logic [15:0] base_peak;       // Lower of motor and servo peak
  logic [15:0] base_cont;       // Never above peak
  logic above;                  // Current over continuous value
  logic tick;                   // One millisecond elapsed
  logic [31:0] full_lvl;
  logic dig_req;
  logic [15:0] dig_lim, spd_lim, stg_lim, mot_lim;
  logic [15:0] load_lim, ana_lim, lim_c;
  logic stg_en;
  logic load_over;

  assign base_peak = min2(i_cfg.motor_peak, i_cfg.servo_peak);
  assign base_cont = min2(min2(i_cfg.motor_cont, i_cfg.servo_cont),
                          base_peak);
  assign above = i_meas.current > base_cont;
  assign tick = st_ff.ms_cnt == 16'(MS_CYCLES - 1);
  // Zero time means the function is switched off
  assign full_lvl = 32'(st_ff.oc_time) * 32'(servo_limit_pkg::MS_PER_S);
  assign dig_req = i_dig_limit | i_can_limit;
  // Settings above full scale are clamped to full scale
  assign dig_lim = 16'((32'(base_peak) *
                        32'(min2(st_ff.dig_lim, 16'(servo_limit_pkg::FULL_PCT))))
                       / 32'(servo_limit_pkg::FULL_PCT));
  // Threshold at or past rated speed steps straight to continuous
  assign spd_lim = (i_cfg.rated_speed <= st_ff.spd_thr) ?
    ((i_meas.speed >= st_ff.spd_thr) ? base_cont : base_peak) :
    lin_red(base_peak, base_cont, i_meas.speed, st_ff.spd_thr,
            i_cfg.rated_speed);
  assign stg_en = (st_ff.stg_warn != 16'h0000) &&
                  (st_ff.stg_stop >= st_ff.stg_warn);
  assign stg_lim = stg_en ? lin_red(base_peak, base_cont,
    i_meas.stage_temp, st_ff.stg_warn, st_ff.stg_stop) : base_peak;
  assign mot_lim = (st_ff.mot_stop >= st_ff.mot_warn) ?
    lin_red(base_peak, base_cont, i_meas.motor_temp, st_ff.mot_warn,
            st_ff.mot_stop) : base_peak;
  assign load_over = i_meas.i2t_load > i_cfg.i2t_limit;
  assign load_lim = load_over ? base_cont : base_peak;
  // Full analog span maps onto zero to full peak current
  assign ana_lim = i_cfg.ana_enable ?
    16'((32'(base_peak) * 32'(i_meas.analog2)) >> 16) : base_peak;

  // Minimum over every active source, each cycle
  always_comb begin
    lim_c = base_peak;
    if (st_ff.oc == servo_limit_pkg::OC_LIMITED) begin
      lim_c = min2(lim_c, base_cont);
    end
    if (dig_req) begin
      lim_c = min2(lim_c, dig_lim);
    end
    lim_c = min2(lim_c, spd_lim);
    lim_c = min2(lim_c, stg_lim);
    lim_c = min2(lim_c, mot_lim);
    lim_c = min2(lim_c, load_lim);
    lim_c = min2(lim_c, ana_lim);
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic signed [15:0] src;
    logic signed [15:0] tgt;
    logic signed [16:0] diff;
    logic [15:0] dsum;
    src = 16'sh0000;
    tgt = 16'sh0000;
    diff = 17'sh00000;
    dsum = 16'h0000;
    nxt_st = st_ff;
    // Millisecond prescaler; long count is a parameter
    nxt_st.ms_cnt = tick ? 16'h0000 : st_ff.ms_cnt + 16'h0001;
    // Time memory fills at one per ms while over
    if (tick && above && st_ff.oc_mem < full_lvl) begin
      nxt_st.oc_mem = st_ff.oc_mem + 32'h00000001;
    end
    // Drains every second ms, so recovery takes twice as long
    if (tick && !above) begin
      nxt_st.drain_ph = ~st_ff.drain_ph;
      if (st_ff.drain_ph && st_ff.oc_mem != 32'h00000000) begin
        nxt_st.oc_mem = st_ff.oc_mem - 32'h00000001;
      end
    end
    // Limited until the memory has fully recovered
    case (st_ff.oc)
      servo_limit_pkg::OC_IDLE: begin
        if (above) begin
          nxt_st.oc = servo_limit_pkg::OC_ACCUM;
        end
      end
      servo_limit_pkg::OC_ACCUM: begin
        if (full_lvl != 32'h00000000 && nxt_st.oc_mem >= full_lvl) begin
          nxt_st.oc = servo_limit_pkg::OC_LIMITED;
        end else if (!above && st_ff.oc_mem == 32'h00000000) begin
          nxt_st.oc = servo_limit_pkg::OC_IDLE;
        end
      end
      servo_limit_pkg::OC_LIMITED: begin
        if (st_ff.oc_mem == 32'h00000000) begin
          nxt_st.oc = servo_limit_pkg::OC_IDLE;
        end
      end
      default: begin
        nxt_st.oc = servo_limit_pkg::OC_IDLE;
      end
    endcase
    nxt_st.limit = lim_c;
    // Flags follow the sources one cycle later
    nxt_st.flags.analog_limit_flag = ana_lim < base_peak;
    nxt_st.flags.dig_limit_flag = dig_req && dig_lim < base_peak;
    nxt_st.flags.speed_limit_flag = spd_lim < base_peak;
    nxt_st.flags.motor_heat_limit_flag = mot_lim < base_peak;
    nxt_st.flags.stage_heat_limit_flag = stg_lim < base_peak;
    nxt_st.flags.stage_heat_to_continuous_flag =
      stg_en && i_meas.stage_temp >= st_ff.stg_stop;
    nxt_st.flags.time_memory_full_flag =
      st_ff.oc == servo_limit_pkg::OC_LIMITED;
    nxt_st.flags.time_memory_prewarn_flag = full_lvl != 32'h00000000 &&
      st_ff.oc_mem * 32'(servo_limit_pkg::FULL_PCT) >
      full_lvl * 32'(servo_limit_pkg::PREWARN_PCT);
    nxt_st.flags.above_continuous_flag = above;
    nxt_st.flags.reduced_flag = lim_c < base_peak;
    nxt_st.flags.stage_temp_warn =
      stg_en && i_meas.stage_temp > st_ff.stg_warn;
    nxt_st.flags.motor_temp_warn = i_meas.motor_temp > st_ff.mot_warn;
    nxt_st.flags.load_warn = load_over ||
      32'(i_meas.i2t_load) * 32'(servo_limit_pkg::FULL_PCT) >
      32'(i_cfg.i2t_limit) * 32'(servo_limit_pkg::LOAD_WARN_PCT);
    nxt_st.flags.oc_warn = st_ff.oc == servo_limit_pkg::OC_LIMITED;
    // Emergency stop latches until reset; stage stop level zero is off
    if ((st_ff.stg_stop != 16'h0000 &&
         i_meas.stage_temp >= st_ff.stg_stop) ||
        i_meas.motor_temp >= st_ff.mot_stop) begin
      nxt_st.estop = 1'b1;
    end
    // Command clamped to the active limit, then ramped
    src = i_cfg.use_fixed ? $signed(st_ff.fix_cmd) : i_meas.command;
    if (src > $signed({1'b0, st_ff.limit[14:0]})) begin
      tgt = $signed({1'b0, st_ff.limit[14:0]});
    end else if (src < -$signed({1'b0, st_ff.limit[14:0]})) begin
      tgt = -$signed({1'b0, st_ff.limit[14:0]});
    end else begin
      tgt = src;
    end
    diff = 17'(tgt) - 17'(st_ff.cmd_ramp);
    if (diff > $signed({2'b00, i_cfg.ramp_step[14:0]})) begin
      nxt_st.cmd_ramp = st_ff.cmd_ramp + $signed({1'b0, i_cfg.ramp_step[14:0]});
    end else if (diff < -$signed({2'b00, i_cfg.ramp_step[14:0]})) begin
      nxt_st.cmd_ramp = st_ff.cmd_ramp - $signed({1'b0, i_cfg.ramp_step[14:0]});
    end else begin
      nxt_st.cmd_ramp = tgt;
    end
    // First-order display filter
    if (i_meas.current >= st_ff.disp) begin
      dsum = (i_meas.current - st_ff.disp) >> servo_limit_pkg::DISP_SHIFT;
      nxt_st.disp = st_ff.disp + dsum;
    end else begin
      dsum = (st_ff.disp - i_meas.current) >> servo_limit_pkg::DISP_SHIFT;
      nxt_st.disp = st_ff.disp - dsum;
    end
    nxt_st.q_err = st_ff.cmd_ramp - $signed(i_meas.iq);
    nxt_st.d_err = $signed(i_meas.direct_axis_reference) - $signed(i_meas.id);
    // PWM compare, signed voltages turned into offset-binary duty
    nxt_st.pwm_cnt = st_ff.pwm_cnt + 10'h001;
    nxt_st.pwm[0] = st_ff.pwm_cnt < (i_meas.vq[15:6] ^ 10'h200);
    nxt_st.pwm[1] = st_ff.pwm_cnt < (i_meas.vd[15:6] ^ 10'h200);
    // Parameter writes; read-only identifiers ignore them
    if (i_par_wr) begin
      case (i_par_id)
        servo_limit_pkg::ID_FIX_CMD: nxt_st.fix_cmd = i_par_wdata;
        servo_limit_pkg::ID_SPD_THR: nxt_st.spd_thr = i_par_wdata;
        servo_limit_pkg::ID_DIG_LIM: nxt_st.dig_lim = i_par_wdata;
        servo_limit_pkg::ID_STG_STOP: nxt_st.stg_stop = i_par_wdata;
        servo_limit_pkg::ID_STG_WARN: nxt_st.stg_warn = i_par_wdata;
        servo_limit_pkg::ID_MOT_WARN: nxt_st.mot_warn = i_par_wdata;
        servo_limit_pkg::ID_MOT_STOP: nxt_st.mot_stop = i_par_wdata;
        servo_limit_pkg::ID_OC_TIME: nxt_st.oc_time = i_par_wdata;
        default: begin
        end
      endcase
    end
    // Reads answer one cycle later; unknown identifiers give zero
    nxt_st.rvalid = i_par_rd;
    nxt_st.rdata = 16'h0000;
    if (i_par_rd) begin
      case (i_par_id)
        servo_limit_pkg::ID_SUM_CUR: nxt_st.rdata = i_meas.current;
        servo_limit_pkg::ID_FIX_CMD: nxt_st.rdata = st_ff.fix_cmd;
        servo_limit_pkg::ID_RAMP_CMD: nxt_st.rdata = st_ff.cmd_ramp;
        servo_limit_pkg::ID_DIRECT_AXIS_REFERENCE: nxt_st.rdata = i_meas.direct_axis_reference;
        servo_limit_pkg::ID_CMD: nxt_st.rdata = i_meas.command;
        servo_limit_pkg::ID_IQ: nxt_st.rdata = i_meas.iq;
        servo_limit_pkg::ID_ID: nxt_st.rdata = i_meas.id;
        servo_limit_pkg::ID_VQ: nxt_st.rdata = i_meas.vq;
        servo_limit_pkg::ID_VD: nxt_st.rdata = i_meas.vd;
        servo_limit_pkg::ID_Q_ERR: nxt_st.rdata = st_ff.q_err;
        servo_limit_pkg::ID_D_ERR: nxt_st.rdata = st_ff.d_err;
        servo_limit_pkg::ID_SPD_THR: nxt_st.rdata = st_ff.spd_thr;
        servo_limit_pkg::ID_DIG_LIM: nxt_st.rdata = st_ff.dig_lim;
        servo_limit_pkg::ID_ACT_LIM: nxt_st.rdata = st_ff.limit;
        servo_limit_pkg::ID_MOT_T: nxt_st.rdata = i_meas.motor_temp;
        servo_limit_pkg::ID_STG_T: nxt_st.rdata = i_meas.stage_temp;
        servo_limit_pkg::ID_AIR_T: nxt_st.rdata = i_meas.air_temp;
        servo_limit_pkg::ID_STG_STOP: nxt_st.rdata = st_ff.stg_stop;
        servo_limit_pkg::ID_STG_WARN: nxt_st.rdata = st_ff.stg_warn;
        servo_limit_pkg::ID_DISP: nxt_st.rdata = st_ff.disp;
        servo_limit_pkg::ID_VOUT: nxt_st.rdata = i_meas.vout;
        servo_limit_pkg::ID_VRED: nxt_st.rdata = i_meas.vred;
        servo_limit_pkg::ID_VTI: nxt_st.rdata = i_meas.vti;
        servo_limit_pkg::ID_MOT_WARN: nxt_st.rdata = st_ff.mot_warn;
        servo_limit_pkg::ID_MOT_STOP: nxt_st.rdata = st_ff.mot_stop;
        servo_limit_pkg::ID_VKP: nxt_st.rdata = i_meas.vkp;
        servo_limit_pkg::ID_OC_TIME: nxt_st.rdata = st_ff.oc_time;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_ff <= '0;
      st_ff.oc <= servo_limit_pkg::OC_IDLE;
      st_ff.fix_cmd <= servo_limit_pkg::RST_FIX_CMD;
      st_ff.spd_thr <= servo_limit_pkg::RST_SPD_THR;
      st_ff.dig_lim <= servo_limit_pkg::RST_DIG_LIM;
      st_ff.stg_stop <= servo_limit_pkg::RST_STG_LVL;
      st_ff.stg_warn <= servo_limit_pkg::RST_STG_LVL;
      st_ff.mot_warn <= servo_limit_pkg::RST_MOT_LVL;
      st_ff.mot_stop <= servo_limit_pkg::RST_MOT_LVL;
      st_ff.oc_time <= servo_limit_pkg::RST_OC_TIME;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_par_rdata = st_ff.rdata;
  assign o_par_valid = st_ff.rvalid;
  assign o_limit = st_ff.limit;
  assign o_cmd_ramp = st_ff.cmd_ramp;
  assign o_flags = st_ff.flags;
  assign o_reduced_led = st_ff.flags.reduced_flag;
  assign o_estop = st_ff.estop;
  assign o_pwm = st_ff.pwm;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  oc_fill_a: assert property (tick && above && st_ff.oc_mem < full_lvl
    |=> st_ff.oc_mem == $past(st_ff.oc_mem) + 32'h00000001)
    else $error("Time memory did not fill");
  oc_limit_a: assert property (st_ff.oc == servo_limit_pkg::OC_LIMITED
    |=> st_ff.limit <= $past(base_cont) && st_ff.flags.oc_warn)
    else $error("Expired time did not limit");
  oc_drain_a: assert property (tick && !above && st_ff.drain_ph
    && st_ff.oc_mem != 32'h00000000
    |=> st_ff.oc_mem == $past(st_ff.oc_mem) - 32'h00000001)
    else $error("Time memory did not drain");
  drain_half_a: assert property (tick && !above && !st_ff.drain_ph
    |=> $stable(st_ff.oc_mem) ##1 !tick)
    else $error("Drain ran at full rate");
  dig_cut_a: assert property (dig_req
    |=> st_ff.limit <= $past(dig_lim))
    else $error("Digital limit not applied");
  stage_stop_a: assert property (st_ff.stg_stop != 16'h0000
    && i_meas.stage_temp >= st_ff.stg_stop |=> o_estop [*2])
    else $error("Stage stop level missed");
  motor_stop_a: assert property (i_meas.motor_temp >= st_ff.mot_stop
    |=> o_estop)
    else $error("Motor stop level missed");
  estop_hold_a: assert property (o_estop |=> o_estop)
    else $error("Emergency stop released");
  oc_time_a: assert property (i_par_wr && i_par_id == servo_limit_pkg::ID_OC_TIME
    |=> st_ff.oc_time == $past(i_par_wdata))
    else $error("Overcurrent time not stored");
  stage_off_a: assert property (!stg_en
    |=> !o_flags.stage_heat_limit_flag && !o_flags.stage_temp_warn)
    else $error("Stage reduction not switched off");
  prewarn_a: assert property ($rose(o_flags.time_memory_full_flag)
    |-> $past(st_ff.oc_mem) * 32'h00000064 > $past(full_lvl) * 32'h00000050)
    else $error("Full before prewarn level");
  above_a: assert property (above |=> o_flags.above_continuous_flag)
    else $error("Above-continuous flag missing");
  // Limit reads zero for one cycle out of reset, before its first update
  summary_a: assert property (!$past(i_rst) && o_limit < $past(base_peak)
    |-> o_reduced_led && o_flags.reduced_flag)
    else $error("Reduction without summary flag");
  base_a: assert property (##1 o_limit <= $past(base_peak))
    else $error("Limit above lower peak");
  speed_a: assert property (i_meas.speed >= i_cfg.rated_speed
    && i_cfg.rated_speed > st_ff.spd_thr |=> o_limit <= $past(base_cont))
    else $error("Speed reduction missing");
  oc_full_c: cover property (st_ff.oc == servo_limit_pkg::OC_LIMITED);
  estop_c: cover property ($rose(o_estop));
  dig_c: cover property (dig_req ##1 o_flags.dig_limit_flag);
  read_c: cover property (i_par_rd ##1 o_par_valid);
endmodule

// >>> plant_model.sv
// Far-side plant: current and temperature sensors of the output stage.
// Assumes the bench sets current and temperatures as plain levels.
`timescale 1ns/10ps
module plant_model (
  input wire logic [15:0] i_cur,
  input wire logic [15:0] i_stg_t,
  input wire logic [15:0] i_mot_t,
  output servo_limit_pkg::meas_t o_meas
);
  // Sensors report levels; air runs cooler than the stage, unused fields read zero
  always_comb begin
    o_meas = '0;
    o_meas.current = i_cur;
    o_meas.iq = i_cur;
    o_meas.stage_temp = i_stg_t;
    o_meas.motor_temp = i_mot_t;
    o_meas.air_temp = i_stg_t >> 1;
  end
endmodule

// >>> tb_top.sv
// Bench for the current-limit block: parameter access and limit paths.
// Assumes the design package and plant_model are compiled first.
`timescale 1ns/10ps
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic dig = 1'b0;
  logic can = 1'b0;
  logic [7:0] pid = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [15:0] cur = 16'h0000;
  logic [15:0] stg = 16'h0000;
  logic [15:0] mot = 16'h0000;
  logic [15:0] rdata, lim, cmd;
  logic valid, led, estop;
  logic [1:0] pwm;
  servo_limit_pkg::meas_t meas;
  servo_limit_pkg::limit_cfg_t cfg;
  servo_limit_pkg::flags_t flg;
  logic [15:0] exp_q[$];
  logic [7:0] ids[7] = '{8'hF0, 8'h46, 8'h3C, 8'h58, 8'h4C, 8'hA2, 8'hA3};
  logic [15:0] rvs[7] = '{16'h0005, 16'h0064, 16'h7FFF, 16'h0000, 16'h0000, 16'h7FFF, 16'h7FFF};
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  int hi;
  // Peak 400/300 and continuous 200/150: the lower pair, 300 and 150, must win; fixed command
  assign cfg = '{16'h0190, 16'h00C8, 16'h012C, 16'h0096, 16'h7FFF, 16'hFFFF, 16'h0001, 1'b0, 1'b1};
  initial forever #20 clk = ~clk;
  plant_model i_plant (.i_cur(cur), .i_stg_t(stg), .i_mot_t(mot), .o_meas(meas));
  // Short millisecond tick keeps the time-memory scenarios brief
  servo_current_limit_reduction #(.MS_CYCLES(4)) i_dut (.i_sys_clk(clk), .i_rst(rst),
    .i_meas(meas), .i_cfg(cfg), .i_dig_limit(dig), .i_can_limit(can), .i_par_wr(wr),
    .i_par_rd(rd), .i_par_id(pid), .i_par_wdata(wd), .o_par_rdata(rdata),
    .o_par_valid(valid), .o_limit(lim), .o_cmd_ramp(cmd), .o_flags(flg),
    .o_reduced_led(led), .o_estop(estop), .o_pwm(pwm));
  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cw(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  // Read pulse; the answer is noted for the monitor
  task automatic rd_par(input logic [7:0] id, input logic [15:0] e);
    cw(1);
    rd = 1'b1;
    pid = id;
    exp_q.push_back(e);
    cw(1);
    rd = 1'b0;
  endtask
  task automatic wr_par(input logic [7:0] id, input logic [15:0] d);
    cw(1);
    wr = 1'b1;
    pid = id;
    wd = d;
    cw(1);
    wr = 1'b0;
  endtask
  task automatic close_out();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Monitor: each valid pulse takes the oldest note; a stray pulse is a mismatch
  always @(posedge clk) begin
    #2;
    if (valid === 1'b1) begin
      if (exp_q.size() > 0) chk(rdata, exp_q.pop_front());
      else chk(16'h0001, 16'h0000);
    end
  end
  // Hang guard, well above the roughly 13400 cycles of the run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      close_out();
    end
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(74));
    cw(6);
    rst = 1'b0;
    foreach (ids[i]) rd_par(ids[i], rvs[i]);
    rd_par(8'h99, 16'h0000);
    cur = 16'($urandom_range(149));
    mot = 16'($urandom_range(1000));
    stg = 16'h0008;
    wr_par(8'h20, 16'h5A5A);
    rd_par(8'h20, cur);
    rd_par(8'h49, mot);
    rd_par(8'h4A, 16'h0008);
    rd_par(8'h4B, 16'h0004);
    chk(lim, 16'h012C);
    wr_par(8'h46, 16'h0028);
    dig = 1'b1;
    cw(2);
    chk(lim, 16'h0078);
    chk(16'(flg.dig_limit_flag & flg.reduced_flag & led), 16'h0001);
    dig = 1'b0;
    can = 1'b1;
    cw(2);
    chk(lim, 16'h0078);
    can = 1'b0;
    cw(2);
    chk(16'(flg.reduced_flag), 16'h0000);
    chk(lim, 16'h012C);
    wr_par(8'h21, 16'h7FFF);
    cw(310);
    chk(cmd, 16'h012C);
    rd_par(8'h22, 16'h012C);
    hi = 0;
    repeat (1024) begin
      cw(1);
      hi += int'(pwm[0]) + int'(pwm[1]);
    end
    chk(16'(hi), 16'h0400);
    wr_par(8'hF0, 16'h0001);
    cur = 16'h00C8;
    cw(2);
    chk(16'(flg.above_continuous_flag), 16'h0001);
    n = 0;
    while (flg.time_memory_full_flag !== 1'b1 && n < 5000) begin
      cw(1);
      n++;
    end
    chk(16'(n > 3900 && n < 4100), 16'h0001);
    chk(lim, 16'h0096);
    chk(16'(flg.oc_warn & flg.time_memory_prewarn_flag), 16'h0001);
    cur = 16'h0064;
    n = 0;
    while (lim !== 16'h012C && n < 9000) begin
      cw(1);
      n++;
    end
    chk(16'(n > 7900 && n < 8100), 16'h0001);
    wr_par(8'h58, 16'h000A);
    wr_par(8'h4C, 16'h0014);
    stg = 16'h000F;
    cw(3);
    chk(16'(flg.stage_temp_warn), 16'h0001);
    chk(lim, 16'h00E1);
    chk(16'(flg.stage_heat_limit_flag), 16'h0001);
    chk(16'(estop), 16'h0000);
    stg = 16'h0014;
    cw(3);
    chk(16'(estop), 16'h0001);
    chk(lim, 16'h0096);
    chk(16'(flg.stage_heat_to_continuous_flag), 16'h0001);
    cw(3);
    chk(16'(exp_q.size()), 16'h0000);
    close_out();
  end
endmodule
